// file: design/psb_host.sv
// host end: burst controller making the link clock by division
module psb_host
    import psb_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [PSB_ADDR_W-1:0] req_addr,
    input wire logic [2:0] req_len,
    input wire logic [PSB_BL_N*PSB_DATA_W-1:0] req_wdata,
    input wire logic [PSB_BL_N*PSB_LANES-1:0] req_mask_n,
    input wire logic pause,
    output logic req_ready,
    output logic rd_valid,
    output logic [PSB_DATA_W-1:0] rd_data,
    output logic done,
    psb_link_if.host link
);
    psb_hstate_t state, next_state;
    logic lclk, next_lclk;
    logic sel_n, next_sel_n;
    logic adv_n, next_adv_n;
    logic we_n, next_we_n;
    logic oe_n, next_oe_n;
    logic ub_n, next_ub_n;
    logic lb_n, next_lb_n;
    logic [PSB_ADDR_W-1:0] addr_o, next_addr_o;
    logic [PSB_DATA_W-1:0] dq_o, next_dq_o;
    logic dq_oe, next_dq_oe;
    logic wr, next_wr;
    logic [2:0] len, next_len;
    logic [PSB_BL_N*PSB_DATA_W-1:0] wbuf, next_wbuf;
    logic [PSB_BL_N*PSB_LANES-1:0] mbuf, next_mbuf;
    logic [3:0] rcnt, next_rcnt;
    logic [15:0] btime, next_btime;
    logic [15:0] stime, next_stime;
    logic stopped, next_stopped;
    logic next_req_ready, next_rd_valid, next_done;
    logic [PSB_DATA_W-1:0] next_rd_data;
    logic [3:0] last;

    assign link.link_clk = lclk;
    assign link.select_n = sel_n;
    assign link.address_valid_n = adv_n;
    assign link.write_n = we_n;
    assign link.output_enable_n = oe_n;
    assign link.upper_byte_enable_n = ub_n;
    assign link.lower_byte_enable_n = lb_n;
    assign link.addr = addr_o;
    assign link.host_dq = dq_o;
    assign link.host_dq_oe = dq_oe;
    assign last = PSB_LAT + {1'b0, len};

    always_comb begin
        next_state = state;
        next_lclk = ~lclk;
        {next_sel_n, next_adv_n, next_we_n, next_oe_n} = {sel_n, adv_n, we_n, oe_n};
        {next_ub_n, next_lb_n, next_addr_o} = {ub_n, lb_n, addr_o};
        {next_dq_o, next_dq_oe, next_wr, next_len} = {dq_o, dq_oe, wr, len};
        {next_wbuf, next_mbuf, next_rcnt} = {wbuf, mbuf, rcnt};
        next_btime = (state == PSB_H_BURST) ? btime + 16'h1 : 16'h0;
        next_stime = (stopped && stime < PSB_BURST_MAX_CYC) ? stime + 16'h1 : stime;
        next_stopped = stopped;
        next_rd_valid = 1'b0;
        next_rd_data = rd_data;
        next_done = 1'b0;
        // clock halts low only inside a read and only while time remains
        if (state == PSB_H_BURST && !wr && pause && !lclk && btime < PSB_SUSPEND_CYC) begin
            next_lclk = 1'b0; // [RULE11] [RULE8]
        end
        case (state)
            PSB_H_IDLE: begin
                if (req_valid) begin
                    next_wr = req_write;
                    next_addr_o = req_addr;
                    next_wbuf = req_wdata;
                    next_mbuf = req_mask_n;
                    next_len = (stime >= PSB_BURST_MAX_CYC || req_len == 3'h0 ||
                                req_len > PSB_LEN_FULL) ? PSB_LEN_FULL : req_len; // [RULE9]
                    next_state = PSB_H_ADV;
                end
            end
            PSB_H_ADV: begin
                if (lclk) begin
                    next_sel_n = 1'b0;
                    next_adv_n = 1'b0; // [RULE7]
                    next_we_n = ~wr;
                    next_oe_n = wr;
                    next_rcnt = 4'h0;
                    next_state = PSB_H_BURST;
                end
            end
            PSB_H_BURST: begin
                if (!lclk && next_lclk) begin
                    next_rcnt = rcnt + 4'h1;
                    if (!wr && rcnt >= PSB_LAT && rcnt < last) begin
                        next_rd_valid = 1'b1; // [RULE16]
                        next_rd_data = link.dq;
                    end
                end else if (lclk) begin
                    next_adv_n = 1'b1;
                    if (rcnt == last) begin
                        next_sel_n = 1'b1; // [RULE10]
                        next_oe_n = 1'b1;
                        next_dq_oe = 1'b0;
                        next_ub_n = 1'b1;
                        next_lb_n = 1'b1;
                        next_done = 1'b1;
                        next_stopped = len < PSB_LEN_FULL;
                        if (len == PSB_LEN_FULL) begin
                            next_stime = 16'h0;
                        end
                        next_state = PSB_H_GAP;
                    end else if (wr && rcnt >= PSB_LAT) begin
                        next_dq_o = wbuf[PSB_DATA_W-1:0];
                        next_dq_oe = 1'b1;
                        {next_ub_n, next_lb_n} = mbuf[PSB_LANES-1:0]; // [RULE6]
                        next_wbuf = wbuf >> PSB_DATA_W;
                        next_mbuf = mbuf >> PSB_LANES;
                    end
                end
            end
            default: begin
                if (lclk) begin
                    next_state = PSB_H_IDLE; // [RULE1]
                end
            end
        endcase
        next_req_ready = (next_state == PSB_H_IDLE);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= PSB_H_IDLE;
            lclk <= 1'b0;
            {sel_n, adv_n, we_n, oe_n, ub_n, lb_n} <= 6'h3f;
            addr_o <= '0;
            dq_o <= '0;
            dq_oe <= 1'b0;
            wr <= 1'b0;
            len <= 3'h0;
            wbuf <= '0;
            mbuf <= '0;
            rcnt <= 4'h0;
            btime <= 16'h0;
            stime <= 16'h0;
            stopped <= 1'b0;
            req_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= '0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            lclk <= next_lclk;
            {sel_n, adv_n, we_n, oe_n} <= {next_sel_n, next_adv_n, next_we_n, next_oe_n};
            {ub_n, lb_n} <= {next_ub_n, next_lb_n};
            addr_o <= next_addr_o;
            dq_o <= next_dq_o;
            dq_oe <= next_dq_oe;
            wr <= next_wr;
            len <= next_len;
            wbuf <= next_wbuf;
            mbuf <= next_mbuf;
            rcnt <= next_rcnt;
            btime <= next_btime;
            stime <= next_stime;
            stopped <= next_stopped;
            req_ready <= next_req_ready;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
            done <= next_done;
        end
    end
endmodule // psb_host

// file: design/psb_pkg.sv
// shared constants and types of the synchronous burst port
package psb_pkg;
    localparam int PSB_DATA_W = 16;
    localparam int PSB_ADDR_W = 8;
    localparam int PSB_DEPTH = 256;
    localparam int PSB_LANES = 2;
    // latency 5, burst length 4, active-low hold-off flag [RULE15]
    localparam int PSB_LAT_N = 5;
    localparam int PSB_BL_N = 4;
    localparam logic [3:0] PSB_LAT = 4'(PSB_LAT_N);
    localparam logic [3:0] PSB_BL = 4'(PSB_BL_N);
    localparam logic [2:0] PSB_LEN_FULL = 3'(PSB_BL_N);
    localparam int PSB_CLK_NS = 10;
    localparam int PSB_BURST_MAX_NS = 2500;
    localparam logic [15:0] PSB_BURST_MAX_CYC = 16'(PSB_BURST_MAX_NS / PSB_CLK_NS);
    // host clocks spent by one unsuspended burst, with select toggles
    localparam logic [15:0] PSB_BURST_OVERHEAD_CYC = 16'(2 * (PSB_LAT_N + PSB_BL_N + 3));
    localparam logic [15:0] PSB_SUSPEND_CYC = PSB_BURST_MAX_CYC - PSB_BURST_OVERHEAD_CYC;
    typedef enum logic [1:0] {
        PSB_H_IDLE,
        PSB_H_ADV,
        PSB_H_BURST,
        PSB_H_GAP
    } psb_hstate_t;
endpackage

// file: design/psb_link_if.sv
// burst link between host controller and pseudo-static ram
interface psb_link_if
    import psb_pkg::*;
();
    logic link_clk;
    logic select_n;
    logic address_valid_n;
    logic write_n;
    logic output_enable_n;
    logic upper_byte_enable_n;
    logic lower_byte_enable_n;
    logic [PSB_ADDR_W-1:0] addr;
    logic [PSB_DATA_W-1:0] host_dq;
    logic host_dq_oe;
    logic [PSB_DATA_W-1:0] dev_dq;
    logic dev_dq_oe;
    logic wait_level;
    logic wait_oe;
    logic [PSB_DATA_W-1:0] dq;
    logic wait_n;

    // resolved wire levels; undriven wait line reads as pulled up
    assign dq = dev_dq_oe ? dev_dq : host_dq;
    assign wait_n = wait_oe ? wait_level : 1'b1;

    modport host (
        output link_clk,
        output select_n,
        output address_valid_n,
        output write_n,
        output output_enable_n,
        output upper_byte_enable_n,
        output lower_byte_enable_n,
        output addr,
        output host_dq,
        output host_dq_oe,
        input dq,
        input wait_n
    );

    modport dev (
        input link_clk,
        input select_n,
        input address_valid_n,
        input write_n,
        input output_enable_n,
        input upper_byte_enable_n,
        input lower_byte_enable_n,
        input addr,
        input dq,
        output dev_dq,
        output dev_dq_oe,
        output wait_level,
        output wait_oe
    );
endinterface

// file: design/psb_device.sv
// device end: pseudo-static ram burst port on the link clock
// Contract
// RULE1 - host starts burst only after previous ends
// RULE2 - burst counts from first edge with strobe low
// RULE3 - hold-off goes low on select or strobe
// RULE4 - hold-off goes high at latency minus one
// RULE5 - hold-off released when select rises
// RULE6 - masked beats leave bytes unwritten, burst continues
// RULE7 - back-to-back bursts need new strobe and address
// RULE8 - host keeps each burst under 2.5 us
// RULE9 - host repeats stops no longer than 2.5 us
// RULE10 - deselect ends burst early, outputs off
// RULE11 - halted clock suspends read data advance
// RULE12 - pending word shown first after resume
// RULE13 - suspend: data floats unless output enabled
// RULE14 - output enabled through suspend holds last word
// RULE15 - latency 5, burst 4, hold-off active low
// RULE16 - one word per edge after latency
module psb_device
    import psb_pkg::*;
(
    input wire logic reset_n,
    psb_link_if.dev link,
    output logic burst_busy
);
    logic rst_meta;
    logic rst_sync_n;
    logic active;
    logic next_active;
    logic is_write;
    logic next_is_write;
    logic adv_prev;
    logic next_adv_prev;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [PSB_ADDR_W-1:0] base;
    logic [PSB_ADDR_W-1:0] next_base;
    logic wait_level;
    logic next_wait_level;
    logic wait_en;
    logic next_wait_en;
    logic rd_drive;
    logic next_rd_drive;
    logic [PSB_DATA_W-1:0] rd_word;
    logic [PSB_DATA_W-1:0] next_rd_word;
    logic [PSB_DATA_W-1:0] stored_word;
    logic starting;
    logic wr_en;
    logic rd_load;
    logic rd_end;
    logic [PSB_LANES-1:0] wr_lane;
    logic [3:0] beat;
    logic [PSB_ADDR_W-1:0] beat_addr;

    // a burst starts on the first rise that sees the strobe low
    assign starting = !link.select_n && !link.address_valid_n && adv_prev;
    assign beat_addr = base + PSB_ADDR_W'(beat);
    assign wr_lane = {~link.upper_byte_enable_n, ~link.lower_byte_enable_n};

    // data lines follow output enable even while the clock stands
    assign link.dev_dq = rd_word;
    assign link.dev_dq_oe = rd_drive & ~link.output_enable_n; // [RULE13] [RULE14]
    assign link.wait_level = wait_level;
    assign link.wait_oe = wait_en;
    assign burst_busy = active;

    // reset is let go only on link clock rises, so no flop sees a half edge
    always_ff @(posedge link.link_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // burst sequencer: start, beat count and end of burst
    always_comb begin
        next_active = active;
        next_is_write = is_write;
        next_adv_prev = link.address_valid_n;
        next_cnt = cnt;
        next_base = base;
        wr_en = 1'b0;
        rd_load = 1'b0;
        rd_end = 1'b0;
        beat = 4'h0;
        if (link.select_n) begin
            // deselect ends any burst
            next_active = 1'b0; // [RULE10]
            next_adv_prev = 1'b1;
        end else if (starting) begin
            // only the first edge of a low strobe starts a burst
            next_active = 1'b1; // [RULE2] [RULE7]
            next_is_write = ~link.write_n;
            next_base = link.addr;
            next_cnt = 4'h1; // [RULE2]
        end else if (active) begin
            // cnt cannot wrap: the burst ends at latency plus length minus one
            next_cnt = cnt + 4'h1;
            if (is_write) begin
                // write data is taken one rise after the read slot
                beat = cnt - PSB_LAT;
                if (cnt >= PSB_LAT) begin
                    wr_en = |wr_lane; // [RULE6] [RULE16]
                    if (cnt == PSB_LAT + PSB_BL - 4'h1) begin
                        next_active = 1'b0;
                    end
                end
            end else begin
                // a read word is loaded one rise ahead of its host sample
                beat = cnt - (PSB_LAT - 4'h1);
                if (cnt >= PSB_LAT - 4'h1 && cnt < PSB_LAT - 4'h1 + PSB_BL) begin
                    rd_load = 1'b1; // [RULE16]
                end else if (cnt == PSB_LAT - 4'h1 + PSB_BL) begin
                    rd_end = 1'b1;
                    next_active = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge link.link_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            active <= 1'b0;
            is_write <= 1'b0;
            adv_prev <= 1'b1;
            cnt <= 4'h0;
            base <= '0;
        end else begin
            active <= next_active;
            is_write <= next_is_write;
            adv_prev <= next_adv_prev;
            cnt <= next_cnt;
            base <= next_base;
        end
    end

    // hold-off flag: low from select or strobe until one rise before data
    always_comb begin
        next_wait_level = wait_level;
        next_wait_en = wait_en;
        if (link.select_n) begin
            next_wait_en = 1'b0; // [RULE5]
        end else if (starting) begin
            next_wait_en = 1'b1;
            next_wait_level = 1'b0; // [RULE3]
        end else if (!active) begin
            // select low with no burst yet: flag not ready
            next_wait_en = 1'b1;
            if (!wait_en) begin
                next_wait_level = 1'b0; // [RULE3]
            end
        end else if (cnt == PSB_LAT - 4'h2) begin
            next_wait_level = 1'b1; // [RULE4]
        end
    end

    always_ff @(posedge link.link_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wait_level <= 1'b0;
            wait_en <= 1'b0;
        end else begin
            wait_level <= next_wait_level;
            wait_en <= next_wait_en;
        end
    end

    // read word: loads only on rises, so a halted clock keeps it pending
    always_comb begin
        next_rd_drive = rd_drive;
        next_rd_word = rd_word;
        if (link.select_n) begin
            next_rd_drive = 1'b0; // [RULE10]
        end else if (starting || rd_end) begin
            // no stale word shown between bursts
            next_rd_drive = 1'b0;
        end else if (rd_load) begin
            next_rd_word = stored_word; // [RULE11] [RULE12]
            next_rd_drive = 1'b1;
        end
    end

    always_ff @(posedge link.link_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_drive <= 1'b0;
            rd_word <= '0;
        end else begin
            rd_drive <= next_rd_drive;
            rd_word <= next_rd_word;
        end
    end

    // one byte-wide array per lane; a disabled lane keeps its old byte
    for (genvar g = 0; g < PSB_LANES; g++) begin : g_lane
        logic [7:0] lane_mem [PSB_DEPTH];
        assign stored_word[g*8 +: 8] = lane_mem[beat_addr];
        always_ff @(posedge link.link_clk) begin
            if (wr_en && wr_lane[g]) begin
                lane_mem[beat_addr] <= link.dq[g*8 +: 8]; // [RULE6]
            end
        end
    end
endmodule // psb_device

// file: tb/psb_link_properties.sv
// link checker: hold-off flag, data drive and suspend behaviour of the device end
module psb_link_properties
    import psb_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic select_n,
    input wire logic address_valid_n,
    input wire logic write_n,
    input wire logic output_enable_n,
    input wire logic [PSB_DATA_W-1:0] dev_dq,
    input wire logic dev_dq_oe,
    input wire logic wait_oe,
    input wire logic wait_n
);
    logic prev_idle;
    logic start;

    // first rise with strobe low after a rise without it
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_idle <= 1'b1;
        end else begin
            prev_idle <= address_valid_n | select_n;
        end
    end
    assign start = !select_n && !address_valid_n && prev_idle;

    property p_wait_low;
        @(posedge link_clk) disable iff (!reset_n) start |=> !wait_n;
    endproperty
    a_wait_low: assert property (p_wait_low) else $error("hold-off not low");

    property p_wait_high;
        @(posedge link_clk) disable iff (!reset_n) start |=> (!wait_n) [*3] ##1 wait_n;
    endproperty
    a_wait_high: assert property (p_wait_high) else $error("hold-off not ready at E3");

    property p_wait_stay;
        @(posedge link_clk) disable iff (!reset_n)
            wait_oe && wait_n && !select_n && address_valid_n |=> wait_n;
    endproperty
    a_wait_stay: assert property (p_wait_stay) else $error("hold-off fell again");

    property p_wait_rel;
        @(posedge link_clk) disable iff (!reset_n) $rose(select_n) |=> !wait_oe;
    endproperty
    a_wait_rel: assert property (p_wait_rel) else $error("hold-off not released");

    property p_oe_float;
        @(posedge link_clk) disable iff (!reset_n) output_enable_n |-> !dev_dq_oe;
    endproperty
    a_oe_float: assert property (p_oe_float) else $error("data driven with oe high");

    property p_stop;
        @(posedge link_clk) disable iff (!reset_n) $rose(select_n) |=> !dev_dq_oe;
    endproperty
    a_stop: assert property (p_stop) else $error("data driven after deselect");

    property p_read_drive;
        @(posedge link_clk) disable iff (!reset_n) start && write_n |-> ##5 dev_dq_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("first word late");

    property p_suspend;
        @(posedge clk) disable iff (!reset_n)
            !link_clk && !$past(link_clk) && dev_dq_oe && $past(dev_dq_oe) |-> $stable(dev_dq);
    endproperty
    a_suspend: assert property (p_suspend) else $error("word moved in suspend");

    c_read: cover property (@(posedge link_clk) disable iff (!reset_n) start && write_n);
    c_write: cover property (@(posedge link_clk) disable iff (!reset_n) start && !write_n);
    c_susp: cover property (@(posedge clk) disable iff (!reset_n) !link_clk && !$past(link_clk));
endmodule // psb_link_properties

// file: tb/testbench.sv
// self-checking bench: host and device ends joined over the burst link
module testbench
    import psb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [PSB_ADDR_W-1:0] req_addr = 8'h00;
    logic [2:0] req_len = 3'h0;
    logic [PSB_BL_N*PSB_DATA_W-1:0] req_wdata = 64'h0;
    logic [PSB_BL_N*PSB_LANES-1:0] req_mask_n = 8'hff;
    logic pause = 1'b0;
    logic req_ready;
    logic rd_valid;
    logic done;
    logic burst_busy;
    logic [PSB_DATA_W-1:0] rd_data;
    logic [PSB_DATA_W-1:0] mem [PSB_DEPTH];
    logic [PSB_DATA_W-1:0] got [$];
    int mismatches = 0;
    int checks = 0;

    psb_link_if link ();
    psb_host u_psb_host (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_len(req_len), .req_wdata(req_wdata),
        .req_mask_n(req_mask_n), .pause(pause), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .done(done), .link(link));
    psb_device u_psb_device (.reset_n(reset_n), .link(link), .burst_busy(burst_busy));
    psb_link_properties u_psb_link_properties (.clk(clk), .reset_n(reset_n),
        .link_clk(link.link_clk), .select_n(link.select_n),
        .address_valid_n(link.address_valid_n), .write_n(link.write_n),
        .output_enable_n(link.output_enable_n), .dev_dq(link.dev_dq),
        .dev_dq_oe(link.dev_dq_oe), .wait_oe(link.wait_oe), .wait_n(link.wait_n));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic timed_out();
        mismatches++;
        $display("Error at %0t: wait ran out", $time);
        print_verdict();
    endtask

    task automatic expect16(input logic [15:0] g, input logic [15:0] e, input string what);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask

    // one host request; reads are compared with the bench's own memory image
    task automatic burst(input logic wr, input logic [7:0] a, input logic [2:0] len,
            input logic [63:0] wd, input logic [7:0] mk, input int hold);
        int n;
        int k;
        int beats;
        beats = (len == 3'h0 || len > 3'h4) ? PSB_BL_N : int'(len);
        for (n = 0; req_ready !== 1'b1; n++) begin
            @(negedge clk);
            if (n > 100) timed_out();
        end
        expect16(16'(burst_busy), 16'h0, "busy while idle");
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_len = len;
        req_wdata = wd;
        req_mask_n = mk;
        @(negedge clk);
        req_valid = 1'b0;
        got.delete();
        k = 0;
        for (n = 0; n < 600 && done !== 1'b1; n++) begin
            @(negedge clk);
            if (rd_valid === 1'b1) got.push_back(rd_data);
            if (hold > 0 && got.size() == 1 && k < hold) begin
                pause = 1'b1;
                k++;
            end else begin
                pause = 1'b0;
            end
        end
        if (done !== 1'b1) timed_out();
        expect16(16'(burst_busy), 16'(beats < PSB_BL_N), "busy at done");
        for (int b = 0; b < beats; b++) begin
            for (int l = 0; l < PSB_LANES; l++) begin
                if (wr && !mk[2*b+l]) mem[8'(a + 8'(b))][8*l +: 8] = wd[16*b+8*l +: 8];
            end
        end
        if (!wr) begin
            expect16(16'(got.size()), 16'(beats), "word count");
            for (int b = 0; b < beats && b < got.size(); b++) begin
                expect16(got[b], mem[8'(a + 8'(b))], "read word");
            end
        end
    endtask

    initial begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        burst(1'b1, 8'h10, 3'h4, 64'h4444_3333_2222_1111, 8'h00, 0);
        burst(1'b1, 8'h10, 3'h4, 64'hdddd_cccc_bbbb_aaaa, 8'h38, 0);
        burst(1'b0, 8'h10, 3'h4, 64'h0, 8'hff, 0);
        burst(1'b0, 8'h10, 3'h4, 64'h0, 8'hff, 40);
        burst(1'b1, 8'hfe, 3'h4, 64'h8888_7777_6666_5555, 8'h00, 0);
        burst(1'b1, 8'hfe, 3'h2, 64'h0123_4567_bbbb_9999, 8'h00, 0);
        burst(1'b0, 8'hfe, 3'h4, 64'h0, 8'hff, 0);
        burst(1'b0, 8'hfe, 3'h1, 64'h0, 8'hff, 0);
        burst(1'b0, 8'h11, 3'h3, 64'h0, 8'hff, 0);
        burst(1'b0, 8'h10, 3'h0, 64'h0, 8'hff, 25);
        print_verdict();
    end
endmodule // testbench
